// File: dv/lvd_cmp_model.sv
// analog comparator stand-in: follows below_req while powered, toggles every cycle while unpowered
`timescale 1ns/100ps
module lvd_cmp_model (
    input wire logic clk, // peripheral clock
    input wire logic [2:0] powered, // comparator and divider power
    input wire logic [2:0] below_req, // bench-chosen input voltage state
    output logic [2:0] cmp_below // comparator outputs
);
    // powered-off outputs wander so the design cannot lean on a stale level
    logic [2:0] dither_reg = 3'h5; // toggles every cycle
    always_ff @(posedge clk) begin
        dither_reg <= ~dither_reg;
    end
    // high means input below the level
    assign cmp_below = (powered & below_req) | (~powered & dither_reg);
endmodule : lvd_cmp_model

// File: dv/lvd_top_bench.sv
// self-checking bench of the level detector through apb
`timescale 1ns/100ps
`include "lvd_defs.svh"
module lvd_top_bench;
    import lvd_pkg::*;
    localparam int CMP = 8; // shortened compare length
    localparam int IDL = 16; // shortened idle length
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000; // byte address
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd; // bus data
    logic pready, pslverr, err; // bus answer
    logic [2:0] below = 3'h0, cmp_below, comp_enable, divider_ground, pin_function_select;
    logic [4:0] level0_sel; // ch0 level code
    logic [2:0] level1_sel, irq_level; // ch1 level, fixed level
    logic [1:0] level2_sel, irq_first; // ch2 level, winner
    logic irq0, irq1, irq2; // request pulses
    wire [2:0] irqs = {irq2, irq1, irq0}; // requests as one word
    logic [2:0] prev = 3'h0; // last cycle requests
    int pc[3] = '{0, 0, 0}; // request pulses per channel
    int mismatches = 0, total_checks = 0;
    logic [4:0] c; // random level code
    logic [13:0] idx; // channel register index
    lvd_top #(.COMPARE_CYCLES(CMP), .IDLE_CYCLES(IDL)) dut (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_below(cmp_below),
        .comp_enable(comp_enable), .divider_ground(divider_ground),
        .pin_function_select(pin_function_select), .level0_sel(level0_sel),
        .level1_sel(level1_sel), .level2_sel(level2_sel), .low_voltage_irq0(irq0),
        .low_voltage_irq1(irq1), .low_voltage_irq2(irq2), .irq_level(irq_level),
        .irq_first(irq_first));
    lvd_cmp_model cmp (.clk(clk), .powered(comp_enable), .below_req(below),
        .cmp_below(cmp_below));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready with no bound of its own
    task automatic apb(input logic wr, input logic [13:0] ix, input logic [7:0] d);
        int n;
        logic [23:0] junk;
        n = 0;
        junk = 24'($urandom());
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= {junk, d};
        @(posedge clk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one more edge so registered outputs have settled for the caller
        @(posedge clk);
    endtask : apb
    // expected level code: out-of-range codes clamp to the top one
    function automatic logic [4:0] lvl_exp(input int ch, input logic [4:0] k);
        int top;
        top = (ch == 0) ? 17 : (ch == 1) ? 4 : 2;
        return (k > top) ? 5'(top) : k;
    endfunction : lvl_exp
    // pulse monitor: width, count and priority of requests
    always @(posedge clk) begin
        if (rst_b) begin
            for (int i = 0; i < 3; i++) begin
                if (irqs[i] === 1'b1) pc[i]++;
            end
            if ((irqs & prev) != 3'h0) chk(1'b1, 1'b0);
            if (irqs != 3'h0) chk(irq_first, irq0 ? 0 : irq1 ? 1 : 2);
            prev <= irqs;
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // hang guard, far beyond the thousand or so cycles the run needs
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(17));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // all registers clear after reset, reserved bits zero
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 14'(`LVD_IDX_CTRL0 + i), 8'h00);
            chk(rd, 32'h0);
        end
        chk(irq_level, 3'h7);
        apb(1'b0, 14'h0450, 8'h00);
        chk(err, 1'b1);
        apb(1'b1, `LVD_IDX_PINSEL, 8'h07);
        chk(pin_function_select, 3'h7);
        // level codes per channel, first pass at the all-ones corner
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 5'h1F : 5'($urandom());
            apb(1'b1, `LVD_IDX_LEVEL0, {3'h0, c});
            chk(level0_sel, lvl_exp(0, c));
            apb(1'b1, `LVD_IDX_CTRL1, {5'h0, c[2:0]});
            chk(level1_sel, lvl_exp(1, {2'h0, c[2:0]}));
            apb(1'b1, `LVD_IDX_CTRL2, {6'h0, c[1:0]});
            chk(level2_sel, lvl_exp(2, {3'h0, c[1:0]}));
        end
        for (int ch = 0; ch < 3; ch++) begin
            idx = 14'(`LVD_IDX_CTRL0 + ch);
            below <= 3'h0;
            apb(1'b1, idx, 8'h82);
            chk({comp_enable[ch], divider_ground[ch]}, 2'h3);
            if (ch == 1) chk(level1_sel, 3'h2);
            repeat (3 * CMP) @(posedge clk);
            apb(1'b0, idx, 8'h00);
            chk(rd[31:4], 28'h8);
            below[ch] <= 1'b1;
            repeat (3 * CMP) @(posedge clk);
            apb(1'b0, idx, 8'h00);
            chk(rd[31:4], 28'h9);
            below[ch] <= 1'b0;
            repeat (3 * CMP) @(posedge clk);
            apb(1'b0, idx, 8'h00);
            chk(rd[4], 1'b1);
            apb(1'b1, idx, 8'h92);
            apb(1'b0, idx, 8'h00);
            chk(rd[4], 1'b1);
            apb(1'b1, idx, 8'h82);
            apb(1'b0, idx, 8'h00);
            chk(rd[4], 1'b0);
            below[ch] <= 1'b1;
            repeat (3 * CMP) @(posedge clk);
            chk(pc[ch], 0);
            apb(1'b1, idx, 8'hB2);
            repeat (3 * CMP) @(posedge clk);
            chk(pc[ch], 1);
            apb(1'b1, idx, 8'hB2);
            repeat (3 * CMP) @(posedge clk);
            chk(pc[ch], 1);
            apb(1'b1, idx, 8'h32);
            chk(comp_enable[ch], 1'b0);
            apb(1'b0, idx, 8'h00);
            chk(rd[4], 1'b1);
            // start already off before the clear
            apb(1'b1, idx, 8'h02);
            apb(1'b0, idx, 8'h00);
            chk(rd[4], 1'b0);
        end
        // all pins enabled at once so the three requests coincide
        apb(1'b1, `LVD_IDX_PINSEL, 8'h00);
        for (int ch = 0; ch < 3; ch++) begin
            apb(1'b1, 14'(`LVD_IDX_CTRL0 + ch), 8'h82);
        end
        repeat (3 * CMP) @(posedge clk);
        for (int ch = 0; ch < 3; ch++) begin
            apb(1'b1, 14'(`LVD_IDX_CTRL0 + ch), 8'hA2);
        end
        below <= 3'h7;
        apb(1'b1, `LVD_IDX_PINSEL, 8'h07);
        repeat (3 * CMP) @(posedge clk);
        for (int i = 0; i < 3; i++) chk(pc[i], 2);
        // interval mode on channel 1: a compare window comes within one period
        apb(1'b1, `LVD_IDX_INTERVAL, 8'h02);
        apb(1'b1, `LVD_IDX_CTRL1, 8'h82);
        repeat (2 * CMP + IDL + 4) @(posedge clk);
        apb(1'b0, `LVD_IDX_CTRL1, 8'h00);
        chk(rd[4], 1'b1);
        end_of_test();
    end
endmodule : lvd_top_bench

// File: rtl/lvd_chan.sv
// one detector channel: control bits, compare timer, held result, edge request
`timescale 1ns/100ps
`include "lvd_defs.svh"
module lvd_chan
    import lvd_pkg::*;
#(
    parameter int LEVEL_W = 3,
    parameter int LEVELS = 5,
    parameter int COMPARE_CYCLES = `LVD_COMPARE_STATES
) (
    input wire logic clk, // peripheral clock
    input wire logic rst_b, // async reset, active low
    input wire logic wr_ctrl, // control register write strobe
    input wire logic wr_lvl, // level field write strobe
    input wire logic wd_start, // written start flag
    input wire logic wd_permit, // written permit flag
    input wire logic wd_result, // written result bit
    input wire logic [LEVEL_W-1:0] wd_level, // written level code
    input wire logic detector_sel, // pin given to detector
    input wire logic gate_on, // interval sequencer allows compare
    input wire logic cmp_below, // comparator: input below level
    output logic detect_start_flag, // comparator powered
    output logic irq_permit_flag, // request gate
    output logic compare_result_flag, // held low-voltage result
    output logic [LEVEL_W-1:0] level_sel, // level code to divider
    output logic cmp_tick, // comparison completed this cycle
    output logic low_voltage_irq // one-cycle request
);
    localparam int CW = $clog2(COMPARE_CYCLES);

    logic start_reg, permit_reg, result_reg, irq_reg; // control state
    logic [LEVEL_W-1:0] level_reg; // level code
    logic [CW-1:0] cnt_reg; // compare state counter
    logic result_next, permit_next;
    logic [CW-1:0] cnt_next;

    wire run = start_reg & detector_sel & gate_on;
    wire tick = run & (cnt_reg == CW'(COMPARE_CYCLES - 1));
    wire permit_rise = wr_ctrl & wd_permit & ~permit_reg;
    // only a written zero clears; permit rise clears too
    wire sw_clear = (wr_ctrl & ~wd_result) | permit_rise;
    wire set_low = tick & cmp_below;
    // out of range codes are held at the top legal level
    wire [LEVEL_W-1:0] lvl_clamp = (wd_level > LEVEL_W'(LEVELS - 1)) ?
        LEVEL_W'(LEVELS - 1) : wd_level;
    wire gated_next = result_next & permit_next;

    // fall is held; no update while stopped; set beats clear
    assign result_next = set_low | (result_reg & ~sw_clear);
    assign permit_next = wr_ctrl ? wd_permit : permit_reg;
    assign cnt_next = tick ? '0 : (run ? cnt_reg + CW'(1) : '0);

    // control bits and result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_reg <= 1'b0;
            permit_reg <= 1'b0;
            result_reg <= 1'b0;
            level_reg <= '0;
            cnt_reg <= '0;
        end else begin
            // start flag powers comparator, divider, ground switch
            if (wr_ctrl) start_reg <= wd_start;
            permit_reg <= permit_next;
            result_reg <= result_next;
            if (wr_lvl) level_reg <= lvl_clamp;
            cnt_reg <= cnt_next;
        end
    end

    // a result held before the permit rise never makes an edge
    // request pulse on rising gated result, one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= gated_next & ~(result_reg & permit_reg);
        end
    end

    assign detect_start_flag = start_reg;
    assign irq_permit_flag = permit_reg;
    assign compare_result_flag = result_reg;
    assign level_sel = level_reg;
    assign cmp_tick = tick;
    assign low_voltage_irq = irq_reg;
endmodule : lvd_chan

// File: rtl/lvd_defs.svh
// register map, field positions, reset values and timing counts of the level detector
`ifndef LVD_DEFS_SVH
`define LVD_DEFS_SVH

// register indices; byte address is four times the index
`define LVD_IDX_CTRL0 14'h0440
`define LVD_IDX_CTRL1 14'h0441
`define LVD_IDX_CTRL2 14'h0442
`define LVD_IDX_PINSEL 14'h0443
`define LVD_IDX_LEVEL0 14'h0444
`define LVD_IDX_INTERVAL 14'h0445

// control register fields
`define LVD_F_START 7
`define LVD_F_PERMIT 5
`define LVD_F_RESULT 4
`define LVD_F_LEVEL_LO 0

// all control bits clear after reset
`define LVD_RST_CTRL 8'h00
`define LVD_RST_PINSEL 3'h0
`define LVD_RST_INTERVAL 3'h0

// comparison length in peripheral clock states per channel
`define LVD_COMPARE_STATES 8064
// idle length between two interval comparisons, in clock cycles
`define LVD_IDLE_STATES 120960

// fixed priority level of the low-voltage requests
`define LVD_IRQ_LEVEL 3'h7

`endif

// File: rtl/lvd_interval.sv
// interval sequencer: alternates a compare window and an idle window
`timescale 1ns/100ps
`include "lvd_defs.svh"
module lvd_interval
    import lvd_pkg::*;
#(
    parameter int COMPARE_CYCLES = `LVD_COMPARE_STATES,
    parameter int IDLE_CYCLES = `LVD_IDLE_STATES
) (
    input wire logic clk, // peripheral clock
    input wire logic rst_b, // async reset, active low
    output logic compare_phase // high during the compare window
);
    localparam int CW = $clog2(COMPARE_CYCLES + IDLE_CYCLES);

    lvd_phase_t phase_reg, phase_next; // current window
    logic [CW-1:0] cnt_reg, cnt_next; // cycles in window
    wire last_cmp = (cnt_reg == CW'(COMPARE_CYCLES - 1));
    wire last_idle = (cnt_reg == CW'(IDLE_CYCLES - 1));

    // window switch, free running so no cpu or timer is needed
    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_reg + CW'(1);
        case (phase_reg)
            LVD_COMPARE: begin
                if (last_cmp) begin
                    phase_next = LVD_IDLE;
                    cnt_next = '0;
                end
            end
            LVD_IDLE: begin
                if (last_idle) begin
                    phase_next = LVD_COMPARE;
                    cnt_next = '0;
                end
            end
            default: begin
                phase_next = LVD_COMPARE;
                cnt_next = '0;
            end
        endcase
    end

    // window state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= LVD_COMPARE;
            cnt_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
        end
    end

    assign compare_phase = (phase_reg == LVD_COMPARE);
endmodule : lvd_interval

// File: rtl/lvd_pkg.sv
// shared types of the level detector
package lvd_pkg;

    // phase of the interval sequencer
    typedef enum logic {
        LVD_COMPARE,
        LVD_IDLE
    } lvd_phase_t;

endpackage : lvd_pkg

// File: rtl/lvd_top.sv
// three-channel battery level detector control with apb register access
`timescale 1ns/100ps
`include "lvd_defs.svh"
module lvd_top
    import lvd_pkg::*;
#(
    parameter int COMPARE_CYCLES = `LVD_COMPARE_STATES,
    parameter int IDLE_CYCLES = `LVD_IDLE_STATES
) (
    input wire logic clk, // peripheral clock, 100 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [15:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [2:0] cmp_below, // comparator outputs, high when below
    output logic [2:0] comp_enable, // comparator and divider power
    output logic [2:0] divider_ground, // divider ground switch closed
    output logic [2:0] pin_function_select, // 1: detector, 0: port
    output logic [4:0] level0_sel, // channel 0 level code
    output logic [2:0] level1_sel, // channel 1 level code
    output logic [1:0] level2_sel, // channel 2 level code
    output logic low_voltage_irq0, // channel 0 request pulse
    output logic low_voltage_irq1, // channel 1 request pulse
    output logic low_voltage_irq2, // channel 2 request pulse
    output logic [2:0] irq_level, // fixed request level
    output logic [1:0] irq_first // winning channel among simultaneous
);
    // address decode
    wire [13:0] idx = paddr[15:2];
    wire hit_c0 = (idx == `LVD_IDX_CTRL0);
    wire hit_c1 = (idx == `LVD_IDX_CTRL1);
    wire hit_c2 = (idx == `LVD_IDX_CTRL2);
    wire hit_pin = (idx == `LVD_IDX_PINSEL);
    wire hit_lv0 = (idx == `LVD_IDX_LEVEL0);
    wire hit_int = (idx == `LVD_IDX_INTERVAL);
    wire mapped = hit_c0 | hit_c1 | hit_c2 | hit_pin | hit_lv0 | hit_int;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    // writes land only on a mapped access phase
    wire wr = access & pwrite & mapped;

    // write data fields; reserved bits 6 and 3 are dropped
    wire wd_start = pwdata[`LVD_F_START];
    wire wd_permit = pwdata[`LVD_F_PERMIT];
    wire wd_result = pwdata[`LVD_F_RESULT];

    logic [2:0] pinsel_reg; // pin use per channel
    logic [2:0] interval_reg; // interval mode per channel
    logic [31:0] prdata_reg; // read data latched at setup
    logic compare_phase; // interval compare window
    logic [2:0] start, permit, result, tick, irq; // per-channel state
    logic [4:0] lv0; // channel 0 level
    logic [2:0] lv1; // channel 1 level
    logic [1:0] lv2; // channel 2 level

    // interval mode gates compare to the window
    wire [2:0] gate = ~interval_reg | {3{compare_phase}};

    // loose configuration registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinsel_reg <= `LVD_RST_PINSEL;
            interval_reg <= `LVD_RST_INTERVAL;
        end else begin
            // low three bits select detector per pin
            if (wr & hit_pin) pinsel_reg <= pwdata[2:0];
            if (wr & hit_int) interval_reg <= pwdata[2:0];
        end
    end

    lvd_chan #(
        .LEVEL_W(5),
        .LEVELS(18),
        .COMPARE_CYCLES(COMPARE_CYCLES)
    ) u_ch0 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_ctrl(wr & hit_c0),
        .wr_lvl(wr & hit_lv0),
        .wd_start(wd_start),
        .wd_permit(wd_permit),
        .wd_result(wd_result),
        .wd_level(pwdata[4:0]),
        .detector_sel(pinsel_reg[0]),
        .gate_on(gate[0]),
        .cmp_below(cmp_below[0]),
        .detect_start_flag(start[0]),
        .irq_permit_flag(permit[0]),
        .compare_result_flag(result[0]),
        .level_sel(lv0),
        .cmp_tick(tick[0]),
        .low_voltage_irq(irq[0])
    );

    // channel 1, five codes; code 010 is 2.4V
    lvd_chan #(
        .LEVEL_W(3),
        .LEVELS(5),
        .COMPARE_CYCLES(COMPARE_CYCLES)
    ) u_ch1 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_ctrl(wr & hit_c1),
        .wr_lvl(wr & hit_c1),
        .wd_start(wd_start),
        .wd_permit(wd_permit),
        .wd_result(wd_result),
        .wd_level(pwdata[2:0]),
        .detector_sel(pinsel_reg[1]),
        .gate_on(gate[1]),
        .cmp_below(cmp_below[1]),
        .detect_start_flag(start[1]),
        .irq_permit_flag(permit[1]),
        .compare_result_flag(result[1]),
        .level_sel(lv1),
        .cmp_tick(tick[1]),
        .low_voltage_irq(irq[1])
    );

    lvd_chan #(
        .LEVEL_W(2),
        .LEVELS(3),
        .COMPARE_CYCLES(COMPARE_CYCLES)
    ) u_ch2 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_ctrl(wr & hit_c2),
        .wr_lvl(wr & hit_c2),
        .wd_start(wd_start),
        .wd_permit(wd_permit),
        .wd_result(wd_result),
        .wd_level(pwdata[1:0]),
        .detector_sel(pinsel_reg[2]),
        .gate_on(gate[2]),
        .cmp_below(cmp_below[2]),
        .detect_start_flag(start[2]),
        .irq_permit_flag(permit[2]),
        .compare_result_flag(result[2]),
        .level_sel(lv2),
        .cmp_tick(tick[2]),
        .low_voltage_irq(irq[2])
    );

    // shared interval sequencer, one window for all channels
    lvd_interval #(
        .COMPARE_CYCLES(COMPARE_CYCLES),
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_interval (
        .clk(clk),
        .rst_b(rst_b),
        .compare_phase(compare_phase)
    );

    // read image of each register; reserved bits read zero
    wire [7:0] img_c0 = {start[0], 1'b0, permit[0], result[0], 4'h0};
    wire [7:0] img_c1 = {start[1], 1'b0, permit[1], result[1], 1'b0, lv1};
    wire [7:0] img_c2 = {start[2], 1'b0, permit[2], result[2], 2'b00, lv2};
    wire [7:0] rd_sel = hit_c0 ? img_c0 :
                        hit_c1 ? img_c1 :
                        hit_c2 ? img_c2 :
                        hit_pin ? {5'h00, pinsel_reg} :
                        hit_lv0 ? {3'h0, lv0} :
                        hit_int ? {5'h00, interval_reg} : 8'h00;

    // read data captured in the setup cycle, held through access
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            prdata_reg <= {24'h000000, rd_sel};
        end
    end

    // zero wait states; unmapped access answers with an error
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // start flag drives power to comparator, divider and ground switch
    assign comp_enable = start;
    assign divider_ground = start;
    assign pin_function_select = pinsel_reg;
    assign level0_sel = lv0;
    assign level1_sel = lv1;
    assign level2_sel = lv2;
    // permit-gated edge requests, one line each
    assign low_voltage_irq0 = irq[0];
    assign low_voltage_irq1 = irq[1];
    assign low_voltage_irq2 = irq[2];
    // requests carry the fixed top level, masking only at the source
    assign irq_level = `LVD_IRQ_LEVEL;
    // lowest channel wins when requests coincide
    assign irq_first = irq[0] ? 2'd0 : (irq[1] ? 2'd1 : (irq[2] ? 2'd2 : 2'd3));

    // helper: cycles since the last tick of channel 1, saturating
    logic [15:0] since_tick; // tick spacing watch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_tick <= 16'h0000;
        end else if (tick[1] | ~(start[1] & pinsel_reg[1] & gate[1])) begin
            since_tick <= 16'h0000;
        end else if (since_tick != 16'hFFFF) begin
            since_tick <= since_tick + 16'h0001;
        end
    end

    sequence permit_rise_s(int ch);
        wr & wd_permit & ~permit[ch];
    endsequence

    sequence gated_rise_s(int ch);
        (result[ch] & permit[ch]) & ~$past(result[ch] & permit[ch]);
    endsequence

    // checks on the channel logic, the read path, the request priority and the request level
    spacing_tick_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        tick[1] |-> since_tick == 16'(COMPARE_CYCLES - 1)
    ) else $error("comparison spacing wrong");

    spacing_run_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        start[1] && pinsel_reg[1] && gate[1] |-> since_tick < 16'(COMPARE_CYCLES)
    ) else $error("comparison overdue");

    power_off_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr & hit_c1 & ~wd_start) |=> (comp_enable[1] == 1'b0) && (tick[1] == 1'b0)
    ) else $error("channel not powered off");

    hold_fall_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        result[0] && !(wr && hit_c0) |=> result[0]
    ) else $error("held result lost");

    below_set_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        tick[2] && cmp_below[2] |=> result[2]
    ) else $error("fall not recorded");

    stop_keep_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !start[1] && !(wr && hit_c1) |=> $stable(result[1])
    ) else $error("result changed while stopped");

    write_one_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr && hit_c1 && wd_result && (permit[1] || !wd_permit) && result[1] |=> result[1]
    ) else $error("writing one changed result");

    write_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr && hit_c0 && !wd_result && !(tick[0] && cmp_below[0]) |=> !result[0]
    ) else $error("writing zero did not clear");

    permit_clear_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (hit_c2 and permit_rise_s(2)) ##0 !(tick[2] && cmp_below[2]) |=> !result[2]
    ) else $error("permit rise did not clear");

    irq_edge_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        gated_rise_s(1) |-> irq[1]
    ) else $error("gated edge made no request");

    irq_gate_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq[0] |-> result[0] && permit[0]
    ) else $error("request without gated result");

    irq_stale_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        permit[1] && result[1] && $past(permit[1] && result[1]) |-> !irq[1]
    ) else $error("request from stale result");

    irq_pulse_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq[2] |=> !irq[2]
    ) else $error("request longer than one cycle");

    pin_gate_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !pinsel_reg[0] |-> !tick[0]
    ) else $error("port pin compared");

    interval_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        interval_reg[1] && !compare_phase |-> !tick[1]
    ) else $error("compare during idle window");

    level_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq_level == 3'h7
    ) else $error("request level not seven");

    reserved_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        setup && !pwrite && hit_c1 |=> prdata[6] == 1'b0 && prdata[3] == 1'b0
    ) else $error("reserved bit read nonzero");

    priority_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq[0] && irq[1] |-> irq_first == 2'd0
    ) else $error("wrong priority winner");

    first_none_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq == 3'h0 |-> irq_first == 2'd3
    ) else $error("winner shown without request");
endmodule : lvd_top
